// ==== shared/slocfg_pkg.sv ====
package slocfg_pkg;

  // ==========================================================
  // Widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int LANES  = 4;
  localparam int SEL_W  = 3;
  localparam int SWG_W  = 3;
  localparam int LVL_W  = 3;
  // Serial symbol width handed to each lane serialiser
  localparam int SYM_W  = 8;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [15:0] OFS_LANE1_MAP  = 16'h05b3;
  localparam logic [15:0] OFS_LANE2_MAP  = 16'h05b5;
  localparam logic [15:0] OFS_LANE3_MAP  = 16'h05b6;
  localparam logic [15:0] OFS_STATUS     = 16'h05b7;
  localparam logic [15:0] OFS_INVERT     = 16'h05bf;
  localparam logic [15:0] OFS_LANE0_SWG  = 16'h05c0;
  localparam logic [15:0] OFS_LANE1_SWG  = 16'h05c1;
  localparam logic [15:0] OFS_LANE2_SWG  = 16'h05c2;
  localparam logic [15:0] OFS_LANE3_SWG  = 16'h05c3;
  localparam logic [15:0] OFS_LANE0_PRE  = 16'h05c4;

  // ==========================================================
  // Reset values
  localparam logic [2:0] RST_LANE1_MAP = 3'h1;
  localparam logic [2:0] RST_LANE2_MAP = 3'h2;
  localparam logic [2:0] RST_LANE3_MAP = 3'h3;
  localparam logic [7:0] RST_INVERT    = 8'h00;
  localparam logic [2:0] RST_SWING     = 3'h1;
  localparam logic [7:0] RST_PRE       = 8'h00;
  localparam logic [7:0] RD_UNMAPPED   = 8'h00;

  // ==========================================================
  // Field positions
  localparam int SEL_MSB      = 2;
  localparam int SWG_MSB      = 2;
  localparam int INV_STRIDE   = 2;
  localparam int PRE_EN_BIT   = 7;
  localparam int PRE_LVL_MSB  = 6;
  localparam int PRE_LVL_LSB  = 4;
  localparam int PRE_RSV_MSB  = 3;
  localparam int STS_DUP_BIT  = 0;
  localparam int STS_SEL_BIT  = 1;
  localparam int STS_SWG_BIT  = 2;
  localparam int STS_LVL_BIT  = 3;

  // ==========================================================
  // Highest legal codes
  localparam logic [2:0] SEL_MAX = 3'h3;
  localparam logic [2:0] SWG_MAX = 3'h2;
  localparam logic [2:0] LVL_MAX = 3'h4;

endpackage

// ==== src/slocfg_lane_xbar.sv ====
`timescale 1ns/100ps
`default_nettype none

module slocfg_lane_xbar (
  input  wire logic                          clk_in,
  input  wire logic                          nrst_in,
  input  wire logic [slocfg_pkg::SYM_W-1:0]  log0_in,
  input  wire logic [slocfg_pkg::SYM_W-1:0]  log1_in,
  input  wire logic [slocfg_pkg::SYM_W-1:0]  log2_in,
  input  wire logic [slocfg_pkg::SYM_W-1:0]  log3_in,
  input  wire logic [slocfg_pkg::SEL_W-1:0]  sel0_in,
  input  wire logic [slocfg_pkg::SEL_W-1:0]  sel1_in,
  input  wire logic [slocfg_pkg::SEL_W-1:0]  sel2_in,
  input  wire logic [slocfg_pkg::SEL_W-1:0]  sel3_in,
  input  wire logic [slocfg_pkg::LANES-1:0]  invert_in,
  output logic      [slocfg_pkg::SYM_W-1:0]  phys0_out,
  output logic      [slocfg_pkg::SYM_W-1:0]  phys1_out,
  output logic      [slocfg_pkg::SYM_W-1:0]  phys2_out,
  output logic      [slocfg_pkg::SYM_W-1:0]  phys3_out
);

  // ==========================================================
  // Lane pick
  // Codes above the last logical lane send zeros rather than alias
  function automatic logic [slocfg_pkg::SYM_W-1:0] pick(
    input logic [slocfg_pkg::SEL_W-1:0] sel,
    input logic [slocfg_pkg::SYM_W-1:0] d0,
    input logic [slocfg_pkg::SYM_W-1:0] d1,
    input logic [slocfg_pkg::SYM_W-1:0] d2,
    input logic [slocfg_pkg::SYM_W-1:0] d3,
    input logic                         inv);
    logic [slocfg_pkg::SYM_W-1:0] w;
    w = '0;
    case (sel)
      3'h0:    w = d0;
      3'h1:    w = d1;
      3'h2:    w = d2;
      3'h3:    w = d3;
      default: w = '0;
    endcase
    // A refused code stays all zeros even on an inverted lane
    pick = (inv && sel <= slocfg_pkg::SEL_MAX) ? ~w : w;
  endfunction

  logic [slocfg_pkg::SYM_W-1:0] p0_d, p1_d, p2_d, p3_d;
  logic [slocfg_pkg::SYM_W-1:0] p0_q, p1_q, p2_q, p3_q;

  always_comb begin
    p0_d = pick(sel0_in, log0_in, log1_in, log2_in, log3_in, invert_in[0]);
    p1_d = pick(sel1_in, log0_in, log1_in, log2_in, log3_in, invert_in[1]);
    p2_d = pick(sel2_in, log0_in, log1_in, log2_in, log3_in, invert_in[2]);
    p3_d = pick(sel3_in, log0_in, log1_in, log2_in, log3_in, invert_in[3]);
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      p0_q <= '0;
      p1_q <= '0;
      p2_q <= '0;
      p3_q <= '0;
    end else begin
      p0_q <= p0_d;
      p1_q <= p1_d;
      p2_q <= p2_d;
      p3_q <= p3_d;
    end
  end

  assign phys0_out = p0_q;
  assign phys1_out = p1_q;
  assign phys2_out = p2_q;
  assign phys3_out = p3_q;

endmodule

`default_nettype wire

// ==== src/slocfg_top.sv ====
// Function
// - Physical lanes 1 to 3 each take a 3-bit selector in bits 2:0 where codes 0 to 3 pick logical lanes 0 to 3.
// - After reset the selectors hold the identity map, lane 1 to logical 1, lane 2 to 2 and lane 3 to 3.
// - Each lane holds a 3-bit swing code where 0 is full driver supply swing, 1 is 0.850 of it and 2 is 0.750 of it.
// - Every swing code resets to 1 and bits 7:3 of each swing register are reserved and read only.
// - Lane 0 pre-emphasis: bit 7 post-tap enable, bits 6:4 level 0 to 12 dB, bits 3:0 reserved, all reset 0.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none

module slocfg_top (
  input  wire logic                           clk_in,
  input  wire logic                           nrst_in,
  // Register port
  input  wire logic [slocfg_pkg::ADDR_W-1:0]  reg_addr_in,
  input  wire logic [slocfg_pkg::DATA_W-1:0]  reg_wdata_in,
  input  wire logic                           reg_wr_in,
  input  wire logic                           reg_rd_in,
  output logic      [slocfg_pkg::DATA_W-1:0]  reg_rdata_out,
  // Lane 0 selector kept by the neighbouring register block
  input  wire logic [slocfg_pkg::SEL_W-1:0]   lane0_sel_in,
  // Logical lane symbols from the framer
  input  wire logic [slocfg_pkg::SYM_W-1:0]   logical_lane0_in,
  input  wire logic [slocfg_pkg::SYM_W-1:0]   logical_lane1_in,
  input  wire logic [slocfg_pkg::SYM_W-1:0]   logical_lane2_in,
  input  wire logic [slocfg_pkg::SYM_W-1:0]   logical_lane3_in,
  // Symbols for the physical lane serialisers
  output logic      [slocfg_pkg::SYM_W-1:0]   serial_out_lane0_out,
  output logic      [slocfg_pkg::SYM_W-1:0]   serial_out_lane1_out,
  output logic      [slocfg_pkg::SYM_W-1:0]   serial_out_lane2_out,
  output logic      [slocfg_pkg::SYM_W-1:0]   serial_out_lane3_out,
  // Driver settings
  output logic      [slocfg_pkg::SEL_W-1:0]   lane1_map_out,
  output logic      [slocfg_pkg::SEL_W-1:0]   lane2_map_out,
  output logic      [slocfg_pkg::SEL_W-1:0]   lane3_map_out,
  output logic      [slocfg_pkg::LANES-1:0]   lane_invert_out,
  output logic      [slocfg_pkg::SWG_W-1:0]   lane0_swing_out,
  output logic      [slocfg_pkg::SWG_W-1:0]   lane1_swing_out,
  output logic      [slocfg_pkg::SWG_W-1:0]   lane2_swing_out,
  output logic      [slocfg_pkg::SWG_W-1:0]   lane3_swing_out,
  output logic                                lane0_post_tap_en_out,
  output logic      [slocfg_pkg::LVL_W-1:0]   lane0_post_tap_lvl_out,
  // Map sanity
  output logic                                lane_map_conflict_out
);

  // ==========================================================
  // Helpers
  function automatic logic is_dup(
    input logic [slocfg_pkg::SEL_W-1:0] s0,
    input logic [slocfg_pkg::SEL_W-1:0] s1,
    input logic [slocfg_pkg::SEL_W-1:0] s2,
    input logic [slocfg_pkg::SEL_W-1:0] s3);
    is_dup = (s0 == s1) || (s0 == s2) || (s0 == s3) ||
             (s1 == s2) || (s1 == s3) || (s2 == s3);
  endfunction

  function automatic logic above(
    input logic [2:0] code,
    input logic [2:0] limit);
    above = code > limit;
  endfunction

  function automatic logic hit(
    input logic [slocfg_pkg::ADDR_W-1:0] a,
    input logic [slocfg_pkg::ADDR_W-1:0] ofs);
    hit = a == ofs;
  endfunction

  // ==========================================================
  // Configuration registers
  logic [slocfg_pkg::SEL_W-1:0] map1_q, map1_d;
  logic [slocfg_pkg::SEL_W-1:0] map2_q, map2_d;
  logic [slocfg_pkg::SEL_W-1:0] map3_q, map3_d;
  logic [7:0]                   inv_q,  inv_d;
  logic [slocfg_pkg::SWG_W-1:0] swg0_q, swg0_d;
  logic [slocfg_pkg::SWG_W-1:0] swg1_q, swg1_d;
  logic [slocfg_pkg::SWG_W-1:0] swg2_q, swg2_d;
  logic [slocfg_pkg::SWG_W-1:0] swg3_q, swg3_d;
  logic [7:0]                   pre0_q, pre0_d;

  always_comb begin
    map1_d = map1_q;
    map2_d = map2_q;
    map3_d = map3_q;
    inv_d  = inv_q;
    swg0_d = swg0_q;
    swg1_d = swg1_q;
    swg2_d = swg2_q;
    swg3_d = swg3_q;
    pre0_d = pre0_q;
    if (reg_wr_in) begin
      if (hit(reg_addr_in, slocfg_pkg::OFS_LANE1_MAP)) begin
        map1_d = reg_wdata_in[slocfg_pkg::SEL_MSB:0];
      end
      if (hit(reg_addr_in, slocfg_pkg::OFS_LANE2_MAP)) begin
        map2_d = reg_wdata_in[slocfg_pkg::SEL_MSB:0];
      end
      if (hit(reg_addr_in, slocfg_pkg::OFS_LANE3_MAP)) begin
        map3_d = reg_wdata_in[slocfg_pkg::SEL_MSB:0];
      end
      // Odd bits are reserved but stay writable and readable
      if (hit(reg_addr_in, slocfg_pkg::OFS_INVERT)) begin
        inv_d = reg_wdata_in;
      end
      // Upper bits of swing writes are dropped
      if (hit(reg_addr_in, slocfg_pkg::OFS_LANE0_SWG)) begin
        swg0_d = reg_wdata_in[slocfg_pkg::SWG_MSB:0];
      end
      if (hit(reg_addr_in, slocfg_pkg::OFS_LANE1_SWG)) begin
        swg1_d = reg_wdata_in[slocfg_pkg::SWG_MSB:0];
      end
      if (hit(reg_addr_in, slocfg_pkg::OFS_LANE2_SWG)) begin
        swg2_d = reg_wdata_in[slocfg_pkg::SWG_MSB:0];
      end
      if (hit(reg_addr_in, slocfg_pkg::OFS_LANE3_SWG)) begin
        swg3_d = reg_wdata_in[slocfg_pkg::SWG_MSB:0];
      end
      if (hit(reg_addr_in, slocfg_pkg::OFS_LANE0_PRE)) begin
        pre0_d = reg_wdata_in;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      map1_q <= slocfg_pkg::RST_LANE1_MAP;
      map2_q <= slocfg_pkg::RST_LANE2_MAP;
      map3_q <= slocfg_pkg::RST_LANE3_MAP;
      inv_q  <= slocfg_pkg::RST_INVERT;
      swg0_q <= slocfg_pkg::RST_SWING;
      swg1_q <= slocfg_pkg::RST_SWING;
      swg2_q <= slocfg_pkg::RST_SWING;
      swg3_q <= slocfg_pkg::RST_SWING;
      pre0_q <= slocfg_pkg::RST_PRE;
    end else begin
      map1_q <= map1_d;
      map2_q <= map2_d;
      map3_q <= map3_d;
      inv_q  <= inv_d;
      swg0_q <= swg0_d;
      swg1_q <= swg1_d;
      swg2_q <= swg2_d;
      swg3_q <= swg3_d;
      pre0_q <= pre0_d;
    end
  end

  // ==========================================================
  // Status
  // Sampled one cycle after the cause so a read sees settled flags
  logic [3:0] sts_q, sts_d;
  logic [slocfg_pkg::LANES-1:0] inv_lanes;

  always_comb begin
    sts_d = '0;
    sts_d[slocfg_pkg::STS_DUP_BIT] = is_dup(lane0_sel_in, map1_q, map2_q, map3_q);
    sts_d[slocfg_pkg::STS_SEL_BIT] = above(lane0_sel_in, slocfg_pkg::SEL_MAX) ||
                                     above(map1_q, slocfg_pkg::SEL_MAX) ||
                                     above(map2_q, slocfg_pkg::SEL_MAX) ||
                                     above(map3_q, slocfg_pkg::SEL_MAX);
    sts_d[slocfg_pkg::STS_SWG_BIT] = above(swg0_q, slocfg_pkg::SWG_MAX) ||
                                     above(swg1_q, slocfg_pkg::SWG_MAX) ||
                                     above(swg2_q, slocfg_pkg::SWG_MAX) ||
                                     above(swg3_q, slocfg_pkg::SWG_MAX);
    sts_d[slocfg_pkg::STS_LVL_BIT] = above(pre0_q[slocfg_pkg::PRE_LVL_MSB:slocfg_pkg::PRE_LVL_LSB],
                                           slocfg_pkg::LVL_MAX);
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      sts_q <= '0;
    end else begin
      sts_q <= sts_d;
    end
  end

  // ==========================================================
  // Read port
  logic [slocfg_pkg::DATA_W-1:0] rdata_q, rdata_d;

  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd_in) begin
      case (reg_addr_in)
        slocfg_pkg::OFS_LANE1_MAP: rdata_d = {5'h00, map1_q};
        slocfg_pkg::OFS_LANE2_MAP: rdata_d = {5'h00, map2_q};
        slocfg_pkg::OFS_LANE3_MAP: rdata_d = {5'h00, map3_q};
        slocfg_pkg::OFS_STATUS:    rdata_d = {4'h0, sts_q};
        slocfg_pkg::OFS_INVERT:    rdata_d = inv_q;
        slocfg_pkg::OFS_LANE0_SWG: rdata_d = {5'h00, swg0_q};
        slocfg_pkg::OFS_LANE1_SWG: rdata_d = {5'h00, swg1_q};
        slocfg_pkg::OFS_LANE2_SWG: rdata_d = {5'h00, swg2_q};
        slocfg_pkg::OFS_LANE3_SWG: rdata_d = {5'h00, swg3_q};
        slocfg_pkg::OFS_LANE0_PRE: rdata_d = pre0_q;
        default:                   rdata_d = slocfg_pkg::RD_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================
  // Lane crossbar
  // Polarity bits sit on even positions only
  assign inv_lanes = {inv_q[3 * slocfg_pkg::INV_STRIDE], inv_q[2 * slocfg_pkg::INV_STRIDE],
                      inv_q[slocfg_pkg::INV_STRIDE], inv_q[0]};

  // Remap takes effect on the next symbol; no lane alignment is kept
  slocfg_lane_xbar u_xbar (
    .clk_in    (clk_in),
    .nrst_in   (nrst_in),
    .log0_in   (logical_lane0_in),
    .log1_in   (logical_lane1_in),
    .log2_in   (logical_lane2_in),
    .log3_in   (logical_lane3_in),
    .sel0_in   (lane0_sel_in),
    .sel1_in   (map1_q),
    .sel2_in   (map2_q),
    .sel3_in   (map3_q),
    .invert_in (inv_lanes),
    .phys0_out (serial_out_lane0_out),
    .phys1_out (serial_out_lane1_out),
    .phys2_out (serial_out_lane2_out),
    .phys3_out (serial_out_lane3_out)
  );

  // ==========================================================
  // Outputs
  assign reg_rdata_out          = rdata_q;
  assign lane1_map_out          = map1_q;
  assign lane2_map_out          = map2_q;
  assign lane3_map_out          = map3_q;
  assign lane_invert_out        = inv_lanes;
  assign lane0_swing_out        = swg0_q;
  assign lane1_swing_out        = swg1_q;
  assign lane2_swing_out        = swg2_q;
  assign lane3_swing_out        = swg3_q;
  assign lane0_post_tap_en_out  = pre0_q[slocfg_pkg::PRE_EN_BIT];
  assign lane0_post_tap_lvl_out = pre0_q[slocfg_pkg::PRE_LVL_MSB:slocfg_pkg::PRE_LVL_LSB];
  assign lane_map_conflict_out  = sts_q[slocfg_pkg::STS_DUP_BIT];

endmodule

`default_nettype wire

// ==== verif/slocfg_asserts.sv ====
`timescale 1ns/100ps
`default_nettype none
// ======================================
// Register and lane checks
module slocfg_asserts (
  input wire logic        clk_in,
  input wire logic        nrst_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic [7:0]  reg_wdata_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [7:0]  reg_rdata_out,
  input wire logic [7:0]  logical_lane0_in,
  input wire logic [7:0]  logical_lane1_in,
  input wire logic [7:0]  logical_lane2_in,
  input wire logic [7:0]  logical_lane3_in,
  input wire logic [7:0]  serial_out_lane1_out,
  input wire logic [2:0]  lane1_map_out,
  input wire logic [3:0]  lane_invert_out,
  input wire logic [2:0]  lane0_swing_out,
  input wire logic        lane0_post_tap_en_out,
  input wire logic [2:0]  lane0_post_tap_lvl_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  logic       w_map;
  logic       w_inv;
  logic       w_swg;
  logic       w_pre;
  logic [7:0] lane1_exp;
  assign w_map = reg_wr_in && reg_addr_in == slocfg_pkg::OFS_LANE1_MAP;
  assign w_inv = reg_wr_in && reg_addr_in == slocfg_pkg::OFS_INVERT;
  assign w_swg = reg_wr_in && reg_addr_in == slocfg_pkg::OFS_LANE0_SWG;
  assign w_pre = reg_wr_in && reg_addr_in == slocfg_pkg::OFS_LANE0_PRE;
  // Refused codes give zeros, never an inverted zero
  always_comb begin
    case (lane1_map_out)
      3'h0: lane1_exp = logical_lane0_in;
      3'h1: lane1_exp = logical_lane1_in;
      3'h2: lane1_exp = logical_lane2_in;
      3'h3: lane1_exp = logical_lane3_in;
      default: lane1_exp = 8'h00;
    endcase
    if (lane_invert_out[1] && lane1_map_out <= 3'h3) lane1_exp = ~lane1_exp;
  end
  property p_map_wr; w_map |=> lane1_map_out == $past(reg_wdata_in[2:0]); endproperty
  a_map_wr: assert property (p_map_wr) else $error("map write lost");
  property p_map_hold; !w_map |=> $stable(lane1_map_out); endproperty
  a_map_hold: assert property (p_map_hold) else $error("map changed");
  property p_rd_map;
    reg_rd_in && reg_addr_in == slocfg_pkg::OFS_LANE1_MAP |=> reg_rdata_out == {5'h00, $past(lane1_map_out)};
  endproperty
  a_rd_map: assert property (p_rd_map) else $error("map read wrong");
  property p_rst;
    disable iff (1'b0) !nrst_in |=> lane1_map_out == 3'h1 && lane0_swing_out == 3'h1 &&
      lane_invert_out == 4'h0 && !lane0_post_tap_en_out && lane0_post_tap_lvl_out == 3'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset value wrong");
  property p_inv;
    w_inv |=> lane_invert_out ==
      {$past(reg_wdata_in[6]), $past(reg_wdata_in[4]), $past(reg_wdata_in[2]), $past(reg_wdata_in[0])};
  endproperty
  a_inv: assert property (p_inv) else $error("invert bits wrong");
  property p_swg; w_swg |=> lane0_swing_out == $past(reg_wdata_in[2:0]); endproperty
  a_swg: assert property (p_swg) else $error("swing write lost");
  property p_swg_rsv;
    reg_rd_in && reg_addr_in == slocfg_pkg::OFS_LANE0_SWG |=> reg_rdata_out == {5'h00, $past(lane0_swing_out)};
  endproperty
  a_swg_rsv: assert property (p_swg_rsv) else $error("swing read wrong");
  property p_pre; w_pre |=> {lane0_post_tap_en_out, lane0_post_tap_lvl_out} == $past(reg_wdata_in[7:4]); endproperty
  a_pre: assert property (p_pre) else $error("pre-emphasis wrong");
  property p_lane; nrst_in |=> serial_out_lane1_out == $past(lane1_exp); endproperty
  a_lane: assert property (p_lane) else $error("lane 1 symbol wrong");
endmodule
`default_nettype wire

// ==== verif/slocfg_rx_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ======================================
// Receiver reassembly, flags maps that are not a permutation
module slocfg_rx_model (
  input wire logic [7:0] sym_in [4],
  input wire logic [2:0] sel_in [4],
  input wire logic [3:0] inv_in,
  output logic     [7:0] rec_out [4],
  output logic           ok_out
);
  int hits [4];
  always_comb begin
    ok_out = 1'b1;
    hits = '{default: 0};
    rec_out = '{default: 8'h00};
    for (int k = 0; k < 4; k++) begin
      if (sel_in[k] <= 3'h3) begin
        rec_out[sel_in[k][1:0]] = inv_in[k] ? ~sym_in[k] : sym_in[k];
        hits[sel_in[k][1:0]]++;
      end
    end
    for (int j = 0; j < 4; j++) begin
      if (hits[j] != 1) ok_out = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== verif/slocfg_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module slocfg_tb_top;
  logic        clk_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic [15:0] reg_addr_in = 16'h0000;
  logic [7:0]  reg_wdata_in = 8'h00;
  logic        reg_wr_in = 1'b0;
  logic        reg_rd_in = 1'b0;
  logic [2:0]  lane0_sel_in = 3'h0;
  logic [7:0]  lg [4] = '{default: 8'h00};
  logic [7:0]  reg_rdata_out, so [4], rec [4], prev [4], e_so [4], m_inv, m_pre, e_rd;
  logic [2:0]  mp [4], sw [4], plv, m_map [4], m_sw [4], p_sel [4];
  logic [3:0]  inv_o, p_inv, m_sts;
  logic        pen, conf, ok, p_ok, go = 1'b0, rnd_sel = 1'b1;
  integer      seed = 73244;
  int          mismatches = 0, n_tests = 0, cycles = 0, i;
  logic [15:0] adr [12] = '{16'h05b3, 16'h05b5, 16'h05b6, 16'h05bf, 16'h05c0, 16'h05c1,
                            16'h05c2, 16'h05c3, 16'h05c4, 16'h05b4, 16'h0000, 16'h05b7};
  always #5 clk_in = ~clk_in;
  slocfg_top uut (.clk_in(clk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .lane0_sel_in(lane0_sel_in),
    .logical_lane0_in(lg[0]), .logical_lane1_in(lg[1]), .logical_lane2_in(lg[2]), .logical_lane3_in(lg[3]),
    .serial_out_lane0_out(so[0]), .serial_out_lane1_out(so[1]), .serial_out_lane2_out(so[2]),
    .serial_out_lane3_out(so[3]), .lane1_map_out(mp[1]), .lane2_map_out(mp[2]), .lane3_map_out(mp[3]),
    .lane_invert_out(inv_o), .lane0_swing_out(sw[0]), .lane1_swing_out(sw[1]), .lane2_swing_out(sw[2]),
    .lane3_swing_out(sw[3]), .lane0_post_tap_en_out(pen), .lane0_post_tap_lvl_out(plv),
    .lane_map_conflict_out(conf));
  slocfg_rx_model rx (.sym_in(so), .sel_in(p_sel), .inv_in(p_inv), .rec_out(rec), .ok_out(ok));
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict();
    if (mismatches == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic op(input logic w, input logic r, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_wr_in <= w;
    reg_rd_in <= r;
    reg_addr_in <= a;
    reg_wdata_in <= d;
  endtask
  function automatic logic [7:0] rd_exp(input logic [15:0] a);
    for (int k = 0; k < 4; k++) begin
      if (k > 0 && a == adr[k - 1]) return {5'h00, m_map[k]};
      if (a == adr[4 + k]) return {5'h00, m_sw[k]};
    end
    if (a == slocfg_pkg::OFS_INVERT) return m_inv;
    if (a == slocfg_pkg::OFS_LANE0_PRE) return m_pre;
    if (a == slocfg_pkg::OFS_STATUS) return {4'h0, m_sts};
    return 8'h00;
  endfunction
  function automatic logic [7:0] so_exp(input int k);
    logic [2:0] s;
    s = (k == 0) ? lane0_sel_in : m_map[k];
    if (s > 3'h3) return 8'h00;
    return m_inv[2 * k] ? ~lg[s[1:0]] : lg[s[1:0]];
  endfunction
  // Status flags: shared selector, selector above 3, swing above 2, level above 4
  function automatic logic [3:0] sts_exp();
    int         n [8];
    logic [3:0] s;
    n = '{default: 0};
    s = 4'h0;
    n[lane0_sel_in]++;
    for (int k = 1; k < 4; k++) n[m_map[k]]++;
    foreach (n[c]) if (n[c] > 1) s[0] = 1'b1;
    for (int k = 0; k < 4; k++) begin
      if ((k > 0 && m_map[k] > 3'h3) || lane0_sel_in > 3'h3) s[1] = 1'b1;
      if (m_sw[k] > 3'h2) s[2] = 1'b1;
    end
    s[3] = m_pre[6:4] > 3'h4;
    return s;
  endfunction
  // ======================================
  // Reference model, updated on the same edges as the design
  always @(posedge clk_in) begin
    go <= 1'b1;
    cycles <= cycles + 1;
    prev <= lg;
    p_ok <= nrst_in;
    p_sel <= '{lane0_sel_in, m_map[1], m_map[2], m_map[3]};
    p_inv <= {m_inv[6], m_inv[4], m_inv[2], m_inv[0]};
    lane0_sel_in <= rnd_sel ? 3'($random(seed)) : 3'h2;
    for (int k = 0; k < 4; k++) begin
      lg[k] <= 8'($random(seed));
      e_so[k] <= nrst_in ? so_exp(k) : 8'h00;
      if (nrst_in && reg_wr_in && k > 0 && reg_addr_in == adr[k - 1]) m_map[k] <= reg_wdata_in[2:0];
      if (nrst_in && reg_wr_in && reg_addr_in == adr[4 + k]) m_sw[k] <= reg_wdata_in[2:0];
    end
    if (!nrst_in) begin
      m_map <= '{3'h0, 3'h1, 3'h2, 3'h3};
      m_sw <= '{default: 3'h1};
      m_inv <= 8'h00;
      m_pre <= 8'h00;
      e_rd <= 8'h00;
      m_sts <= 4'h0;
    end else begin
      m_sts <= sts_exp();
      if (reg_wr_in && reg_addr_in == slocfg_pkg::OFS_INVERT) m_inv <= reg_wdata_in;
      if (reg_wr_in && reg_addr_in == slocfg_pkg::OFS_LANE0_PRE) m_pre <= reg_wdata_in;
      if (reg_rd_in) e_rd <= rd_exp(reg_addr_in);
    end
  end
  always @(negedge clk_in) begin
    if (go) begin
      check("rdata", reg_rdata_out, e_rd);
      for (int k = 0; k < 4; k++) check("serial", so[k], e_so[k]);
      check("maps", {mp[1], mp[2], mp[3]}, {m_map[1], m_map[2], m_map[3]});
      check("swing", {sw[0], sw[1], sw[2], sw[3]}, {m_sw[0], m_sw[1], m_sw[2], m_sw[3]});
      check("invert", inv_o, {m_inv[6], m_inv[4], m_inv[2], m_inv[0]});
      check("pre", {pen, plv}, m_pre[7:4]);
      check("conflict", conf, m_sts[0]);
      if (ok === 1'b1 && p_ok) for (int j = 0; j < 4; j++) check("rx", rec[j], prev[j]);
    end
  end
  always @(posedge clk_in) begin
    if (cycles == 5000) begin
      mismatches++;
      give_verdict();
    end
  end
  initial begin
    repeat (20) @(posedge clk_in);
    nrst_in <= 1'b1;
    for (i = 0; i < 12; i++) op(1'b0, 1'b1, adr[i], 8'h00);
    // Back to back random traffic; status and unmapped writes must be dropped
    repeat (400) begin
      i = $unsigned($random(seed)) % 12;
      if ($random(seed) % 2 == 0) op(1'b0, 1'b1, adr[i], 8'h00);
      else op(1'b1, 1'b0, adr[i], 8'($random(seed)));
    end
    rnd_sel <= 1'b0;
    op(1'b1, 1'b0, adr[0], 8'h00);
    op(1'b1, 1'b0, adr[1], 8'h03);
    op(1'b1, 1'b0, adr[2], 8'h01);
    op(1'b1, 1'b0, adr[3], 8'h14);
    op(1'b0, 1'b0, adr[3], 8'h00);
    repeat (20) @(posedge clk_in);
    nrst_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    nrst_in <= 1'b1;
    for (i = 0; i < 12; i++) op(1'b0, 1'b1, adr[i], 8'h00);
    op(1'b0, 1'b0, adr[0], 8'h00);
    repeat (3) @(posedge clk_in);
    give_verdict();
  end
endmodule
bind slocfg_top slocfg_asserts u_chk (.clk_in(clk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .logical_lane0_in(logical_lane0_in), .logical_lane1_in(logical_lane1_in), .logical_lane2_in(logical_lane2_in),
  .logical_lane3_in(logical_lane3_in), .serial_out_lane1_out(serial_out_lane1_out), .lane1_map_out(lane1_map_out),
  .lane_invert_out(lane_invert_out), .lane0_swing_out(lane0_swing_out),
  .lane0_post_tap_en_out(lane0_post_tap_en_out), .lane0_post_tap_lvl_out(lane0_post_tap_lvl_out));
`default_nettype wire
